// file: hw/slave_fifo_rw_sequencer.v
// Slave FIFO port: external master reads and writes endpoint FIFOs, sync or async.
//
// Summary of operation
// RQ1 - Master sets endpoint address at least 25 ns before first synchronous strobe.
// RQ2 - Output enable only switches data drivers; it never moves a FIFO pointer.
// RQ3 - Synchronous read: word at read pointer is prefetched, visible when output enabled.
// RQ4 - Read needs chip select and read strobe; master asserts select first or together.
// RQ5 - Synchronous: each interface clock edge with read strobe advances pointer, shows next word.
// RQ6 - Synchronous burst read: strobes held, one word per interface clock edge.
// RQ7 - Synchronous write: master sets data before the sampling clock edge.
// RQ8 - Write needs chip select and write strobe; master asserts select first or together.
// RQ9 - Synchronous: edge with write strobe stores word, bumps pointer, updates flags.
// RQ10 - Synchronous burst write: one word captured per edge until strobe drops.
// RQ11 - Synchronous packet end commits short packet, same edge as last word or later.
// RQ12 - Packet end on the same edge as a write includes that word.
// RQ13 - Master holds endpoint address steady while packet end is asserted.
// RQ14 - Chip select may be tied asserted; strobes alone then operate the port.
// RQ15 - Asynchronous: output enable before a read shows word from previous read.
// RQ16 - Asynchronous: read strobe falling edge presents current word, then bumps pointer.
// RQ17 - Asynchronous: read strobe and output enable may be tied together.
// RQ18 - Asynchronous write: master sets data before write strobe rising edge.
// RQ19 - Asynchronous: write strobe rising edge stores word, post-increments, updates flags.
// RQ20 - Asynchronous: master never overlaps packet end with write strobe.
// RQ21 - Endpoint address selects FIFO for data, strobes and flags.
`timescale 1ns/100ps
`include "slave_fifo_map.vh"
module slave_fifo_rw_sequencer #(
    parameter DATA_W     = `SFM_DATA_W,
    parameter EP_SEL_W   = `SFM_EP_SEL_W,
    parameter EP_IDX_W   = `SFM_EP_IDX_W,
    parameter DEPTH_LOG2 = `SFM_DEPTH_LOG2
) (
    input  wire                  clk,
    input  wire                  arst_n,
    input  wire                  interface_clock,
    input  wire                  async_mode,
    input  wire                  fifo_chip_select_n,
    input  wire                  fifo_output_enable_n,
    input  wire                  fifo_read_strobe_n,
    input  wire                  fifo_write_strobe_n,
    input  wire                  packet_commit_strobe_n,
    input  wire [EP_SEL_W-1:0]   endpoint_select,
    input  wire [DATA_W-1:0]     fifo_data_in,
    output reg  [DATA_W-1:0]     fifo_data_out,
    output reg                   fifo_data_oe,
    output reg                   fifo_empty_flag,
    output reg                   fifo_full_flag,
    input  wire                  usb_push_valid,
    input  wire [EP_IDX_W-1:0]   usb_push_ep,
    input  wire [DATA_W-1:0]     usb_push_data,
    output wire                  usb_push_ready,
    input  wire                  usb_pop_req,
    input  wire [EP_IDX_W-1:0]   usb_pop_ep,
    output wire                  usb_pop_ready,
    output wire [DATA_W-1:0]     usb_pop_data,
    output reg                   usb_pop_data_valid,
    output reg                   commit_pulse,
    output reg  [EP_IDX_W-1:0]   commit_ep,
    output reg  [DEPTH_LOG2:0]   commit_len
);

    // ********
    // Local sizes
    // ********
    localparam NEP = 1 << EP_IDX_W;
    localparam PW  = DEPTH_LOG2 + 1;
    localparam MAW = EP_IDX_W + DEPTH_LOG2;
    localparam SW  = DATA_W + `SFM_CTRL_W + EP_SEL_W;

    integer i;

    // ********
    // Pointer helpers
    // ********
    function f_empty;
        input [PW-1:0] w;
        input [PW-1:0] r;
        begin
            f_empty = (w == r);
        end
    endfunction

    function f_full;
        input [PW-1:0] w;
        input [PW-1:0] r;
        begin
            f_full = (w[PW-2:0] == r[PW-2:0]) && (w[PW-1] != r[PW-1]);
        end
    endfunction

    function ep_valid;
        input [EP_SEL_W-1:0] ep;
        begin
            ep_valid = ~|(ep >> EP_IDX_W);
        end
    endfunction

    // ********
    // Pin synchronisation
    // ********
    wire [SW-1:0] pin_s;
    reg  [SW-1:0] pin_p_q;

    pin_sync #(
        .W (SW)
    ) u_pin_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({endpoint_select, async_mode, interface_clock, fifo_chip_select_n,
                  fifo_output_enable_n, fifo_read_strobe_n, fifo_write_strobe_n,
                  packet_commit_strobe_n, fifo_data_in}),
        .q      (pin_s)
    );

    // Previous-cycle copy gives edges, and samples taken before an interface clock edge.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_p_q <= {SW{1'b1}};
        end else begin
            pin_p_q <= pin_s;
        end
    end

    wire [DATA_W-1:0]   prv_data  = pin_p_q[DATA_W-1:0];
    wire [EP_SEL_W-1:0] cur_ep    = pin_s[DATA_W+`SFM_PIN_EP +: EP_SEL_W];
    wire [EP_SEL_W-1:0] prv_ep    = pin_p_q[DATA_W+`SFM_PIN_EP +: EP_SEL_W];
    wire                cur_async = pin_s[DATA_W+`SFM_PIN_ASYNC];
    wire                cur_interface_clock = pin_s[DATA_W+`SFM_PIN_INTERFACE_CLOCK];
    wire                prv_interface_clock = pin_p_q[DATA_W+`SFM_PIN_INTERFACE_CLOCK];
    wire                cur_cs_n  = pin_s[DATA_W+`SFM_PIN_CS];
    wire                prv_cs_n  = pin_p_q[DATA_W+`SFM_PIN_CS];
    wire                cur_oe_n  = pin_s[DATA_W+`SFM_PIN_OE];
    wire                cur_rd_n  = pin_s[DATA_W+`SFM_PIN_RD];
    wire                prv_rd_n  = pin_p_q[DATA_W+`SFM_PIN_RD];
    wire                cur_wr_n  = pin_s[DATA_W+`SFM_PIN_WR];
    wire                prv_wr_n  = pin_p_q[DATA_W+`SFM_PIN_WR];
    wire                cur_pkt_n = pin_s[DATA_W+`SFM_PIN_PKT];
    wire                prv_pkt_n = pin_p_q[DATA_W+`SFM_PIN_PKT];

    // ********
    // Strobe events
    // ********
    reg wr_arm_q;

    wire interface_clock_rise = cur_interface_clock & ~prv_interface_clock;
    wire cur_ok     = ep_valid(cur_ep);
    wire ev_ok      = ep_valid(prv_ep);
    wire [EP_IDX_W-1:0] sel  = cur_ep[EP_IDX_W-1:0];
    wire [EP_IDX_W-1:0] ev_i = prv_ep[EP_IDX_W-1:0];

    // A tied-low chip select simply leaves these terms always true.
    wire sync_rd = interface_clock_rise & ~prv_rd_n & ~prv_cs_n;              // [RQ4] [RQ5] [RQ6] [RQ14]
    wire async_rd = prv_rd_n & ~cur_rd_n & ~cur_cs_n;               // [RQ4] [RQ16] [RQ14]
    wire sync_wr = interface_clock_rise & ~prv_wr_n & ~prv_cs_n;              // [RQ8] [RQ9] [RQ10] [RQ14]
    wire async_wr = ~prv_wr_n & cur_wr_n & wr_arm_q;                // [RQ19]
    wire sync_pkt = interface_clock_rise & ~prv_pkt_n;                        // [RQ11]
    wire async_pkt = prv_pkt_n & ~cur_pkt_n;

    wire rd_evt  = (cur_async ? async_rd : sync_rd) & ev_ok;        // [RQ21]
    wire wr_evt  = (cur_async ? async_wr : sync_wr) & ev_ok;        // [RQ21]
    wire pkt_evt = (cur_async ? async_pkt : sync_pkt) & ev_ok;

    // Chip select is caught while the async write strobe is low; the write lands at release.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_arm_q <= 1'b0;
        end else if (cur_wr_n) begin
            wr_arm_q <= 1'b0;
        end else if (!cur_cs_n) begin
            wr_arm_q <= 1'b1;                                       // [RQ8]
        end
    end

    // ********
    // Endpoint pointers
    // ********
    // Toward master: usb side writes, master reads. From master: master writes, usb side reads.
    reg [PW-1:0] tm_w_q [0:NEP-1];
    reg [PW-1:0] tm_r_q [0:NEP-1];
    reg [PW-1:0] fm_w_q [0:NEP-1];
    reg [PW-1:0] fm_r_q [0:NEP-1];
    reg [PW-1:0] fm_c_q [0:NEP-1];

    wire rd_do = rd_evt & ~f_empty(tm_w_q[ev_i], tm_r_q[ev_i]);
    wire wr_do = wr_evt & ~f_full(fm_w_q[ev_i], fm_r_q[ev_i]);
    wire [PW-1:0] commit_to = wr_do ? fm_w_q[ev_i] + 1'b1 : fm_w_q[ev_i];   // [RQ12]

    assign usb_push_ready = ~f_full(tm_w_q[usb_push_ep], tm_r_q[usb_push_ep]);
    assign usb_pop_ready  = ~f_empty(fm_c_q[usb_pop_ep], fm_r_q[usb_pop_ep]);
    wire push_do = usb_push_valid & usb_push_ready;
    wire pop_do  = usb_pop_req & usb_pop_ready;

    // Output enable is absent from every pointer update.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < NEP; i = i + 1) begin
                tm_w_q[i] <= {PW{1'b0}};
                tm_r_q[i] <= {PW{1'b0}};
                fm_w_q[i] <= {PW{1'b0}};
                fm_r_q[i] <= {PW{1'b0}};
                fm_c_q[i] <= {PW{1'b0}};
            end
        end else begin
            if (rd_do) begin
                tm_r_q[ev_i] <= tm_r_q[ev_i] + 1'b1;               // [RQ2] [RQ5] [RQ16]
            end
            if (wr_do) begin
                fm_w_q[ev_i] <= fm_w_q[ev_i] + 1'b1;               // [RQ9] [RQ19]
            end
            if (pkt_evt) begin
                fm_c_q[ev_i] <= commit_to;                          // [RQ11] [RQ12]
            end
            if (push_do) begin
                tm_w_q[usb_push_ep] <= tm_w_q[usb_push_ep] + 1'b1;
            end
            if (pop_do) begin
                fm_r_q[usb_pop_ep] <= fm_r_q[usb_pop_ep] + 1'b1;
            end
        end
    end

    // ********
    // Word storage
    // ********
    wire [DATA_W-1:0] tm_rdata;

    // The addressed endpoint's read word is fetched continuously.
    fifo_store #(
        .W  (DATA_W),
        .AW (MAW)
    ) u_to_master (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (push_do),
        .wr_addr ({usb_push_ep, tm_w_q[usb_push_ep][PW-2:0]}),
        .wr_data (usb_push_data),
        .rd_addr ({sel, tm_r_q[sel][PW-2:0]}),                    // [RQ3] [RQ21]
        .rd_data (tm_rdata)
    );

    // Write data was sampled in the cycle before the strobe edge was seen.
    fifo_store #(
        .W  (DATA_W),
        .AW (MAW)
    ) u_from_master (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (wr_do),                                           // [RQ9] [RQ19]
        .wr_addr ({ev_i, fm_w_q[ev_i][PW-2:0]}),
        .wr_data (prv_data),
        .rd_addr ({usb_pop_ep, fm_r_q[usb_pop_ep][PW-2:0]}),
        .rd_data (usb_pop_data)
    );

    // ********
    // Master-facing data, drivers and flags
    // ********
    // In async mode the word is held between reads, so an early enable shows the previous one.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_data_out <= {DATA_W{1'b0}};
        end else if (!cur_async) begin
            fifo_data_out <= tm_rdata;                              // [RQ3] [RQ5] [RQ6]
        end else if (rd_evt) begin
            fifo_data_out <= tm_rdata;                              // [RQ15] [RQ16] [RQ17]
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_data_oe    <= 1'b0;
            fifo_empty_flag <= `SFM_RST_EMPTY;
            fifo_full_flag  <= `SFM_RST_FULL;
        end else begin
            fifo_data_oe    <= ~cur_oe_n & cur_ok;                  // [RQ2] [RQ17]
            fifo_empty_flag <= ~cur_ok | f_empty(tm_w_q[sel], tm_r_q[sel]);   // [RQ21]
            fifo_full_flag  <= ~cur_ok | f_full(fm_w_q[sel], fm_r_q[sel]);    // [RQ9] [RQ19]
        end
    end

    // ********
    // Usb-side events
    // ********
    // Only committed words are offered to the usb side, so the commit length matters.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            usb_pop_data_valid <= 1'b0;
            commit_pulse       <= 1'b0;
            commit_ep          <= {EP_IDX_W{1'b0}};
            commit_len         <= {PW{1'b0}};
        end else begin
            usb_pop_data_valid <= pop_do;
            commit_pulse       <= pkt_evt;
            if (pkt_evt) begin
                commit_ep  <= ev_i;                                 // [RQ13]
                commit_len <= commit_to - fm_c_q[ev_i];             // [RQ12]
            end
        end
    end

endmodule

// file: hw/slave_fifo_map.vh
// Constants shared by the slave FIFO port design files.
`ifndef SLAVE_FIFO_MAP_VH
`define SLAVE_FIFO_MAP_VH

// ********
// Bus and FIFO geometry
// ********
`define SFM_DATA_W        16
`define SFM_EP_SEL_W      3
`define SFM_EP_IDX_W      2
`define SFM_DEPTH_LOG2    6

// ********
// Pin vector layout after synchronisation, above the data bits
// ********
`define SFM_PIN_PKT       0
`define SFM_PIN_WR        1
`define SFM_PIN_RD        2
`define SFM_PIN_OE        3
`define SFM_PIN_CS        4
`define SFM_PIN_INTERFACE_CLOCK     5
`define SFM_PIN_ASYNC     6
`define SFM_PIN_EP        7
`define SFM_CTRL_W        7

// ********
// Reset values of outputs
// ********
`define SFM_RST_EMPTY     1'b1
`define SFM_RST_FULL      1'b0

`endif

// file: hw/pin_sync.v
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/100ps
module pin_sync #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    // Only the second stage is read, so a metastable first stage never reaches logic.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= {W{1'b1}};
            s2_q <= {W{1'b1}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;

endmodule

// file: hw/fifo_store.v
// Simple dual-port word memory with registered read data.
`timescale 1ns/100ps
module fifo_store #(
    parameter W  = 16,
    parameter AW = 8
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [W-1:0]  wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [W-1:0]  rd_data
);

    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read every cycle so the addressed word is always prefetched.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= {W{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// file: bench/slave_fifo_properties.sv
// Concurrent checks on the slave FIFO port pins.
`timescale 1ns/100ps
module slave_fifo_props #(
    parameter DATA_W     = 16,
    parameter EP_SEL_W   = 3,
    parameter EP_IDX_W   = 2,
    parameter DEPTH_LOG2 = 6
) (
    input wire                clk,
    input wire                arst_n,
    input wire                async_mode,
    input wire                fifo_output_enable_n,
    input wire                fifo_read_strobe_n,
    input wire                packet_commit_strobe_n,
    input wire [EP_SEL_W-1:0] endpoint_select,
    input wire [DATA_W-1:0]   fifo_data_out,
    input wire                fifo_data_oe,
    input wire                fifo_empty_flag,
    input wire                fifo_full_flag,
    input wire                usb_pop_req,
    input wire                usb_pop_ready,
    input wire                usb_pop_data_valid,
    input wire                commit_pulse,
    input wire [DEPTH_LOG2:0] commit_len
);
    logic [3:0] quiet_q;
    logic [3:0] pkt_age_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ********
    // Helper counters
    // ********
    // Pins pass a synchroniser, so quiet periods are counted, not single cycles.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quiet_q   <= 4'h0;
            pkt_age_q <= 4'hF;
        end else begin
            quiet_q   <= (!async_mode || !fifo_read_strobe_n || !$stable(endpoint_select)) ? 4'h0 :
                         (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
            pkt_age_q <= !packet_commit_strobe_n ? 4'h0 : (pkt_age_q == 4'hF) ? pkt_age_q : pkt_age_q + 4'h1;
        end
    end
    // ********
    // Properties
    // ********
    sequence oe_held_on;
        (!fifo_output_enable_n && endpoint_select < 4)[*5];
    endsequence
    sequence oe_held_off;
        fifo_output_enable_n[*5];
    endsequence
    a_oe_drives_bus: assert property (oe_held_on |-> fifo_data_oe)
        else $error("bus not driven");
    a_oe_releases_bus: assert property (oe_held_off |-> !fifo_data_oe)
        else $error("bus driven, enable off");
    a_bad_addr_flags: assert property ((endpoint_select >= 4)[*6] |-> fifo_empty_flag && fifo_full_flag)
        else $error("unused address flags");
    a_commit_one_cycle: assert property (commit_pulse |=> !commit_pulse)
        else $error("long commit pulse");
    a_commit_len_max: assert property (commit_pulse |-> commit_len <= (1 << DEPTH_LOG2))
        else $error("commit too long");
    a_commit_has_cause: assert property (commit_pulse |-> pkt_age_q < 4'hA)
        else $error("commit without cause");
    a_pop_answered: assert property (usb_pop_req && usb_pop_ready |=> usb_pop_data_valid)
        else $error("pop not answered");
    a_pop_refused: assert property (!(usb_pop_req && usb_pop_ready) |=> !usb_pop_data_valid)
        else $error("unasked pop answer");
    a_async_data_hold: assert property (quiet_q >= 4'h8 |-> $stable(fifo_data_out))
        else $error("async word changed");
endmodule
bind slave_fifo_rw_sequencer slave_fifo_props #(
    .DATA_W(DATA_W), .EP_SEL_W(EP_SEL_W), .EP_IDX_W(EP_IDX_W), .DEPTH_LOG2(DEPTH_LOG2)
) slave_fifo_props_inst (
    .clk(clk), .arst_n(arst_n), .async_mode(async_mode), .fifo_output_enable_n(fifo_output_enable_n),
    .fifo_read_strobe_n(fifo_read_strobe_n), .packet_commit_strobe_n(packet_commit_strobe_n),
    .endpoint_select(endpoint_select), .fifo_data_out(fifo_data_out), .fifo_data_oe(fifo_data_oe),
    .fifo_empty_flag(fifo_empty_flag), .fifo_full_flag(fifo_full_flag), .usb_pop_req(usb_pop_req),
    .usb_pop_ready(usb_pop_ready), .usb_pop_data_valid(usb_pop_data_valid),
    .commit_pulse(commit_pulse), .commit_len(commit_len)
);

// file: bench/master_model.sv
// External master model: interface clock, strobes, address and data bus.
`timescale 1ns/100ps
module master_model (
    input  wire         clk,
    input  wire  [15:0] dut_data,
    input  wire         dut_oe,
    output logic        interface_clock,
    output logic        async_mode,
    output logic        cs_n,
    output logic        oe_n,
    output logic        rd_n,
    output logic        wr_n,
    output logic        pkt_n,
    output logic [2:0]  ep_sel,
    output wire  [15:0] bus
);
    logic        drive;
    logic [15:0] wdata;
    logic [15:0] last_q;
    // ********
    // Pins and bus
    // ********
    // The offset keeps link edges off the system clock edges.
    initial begin
        interface_clock = 1'b0;
        async_mode = 1'b0;
        {cs_n, oe_n, rd_n, wr_n, pkt_n} = 5'h1F;
        ep_sel = 3'h0;
        drive = 1'b0;
        wdata = 16'h0000;
        last_q = 16'h0000;
        #1.3;
        forever #62.5 interface_clock = ~interface_clock;
    end
    always @(posedge clk) begin
        if (drive) last_q <= wdata;
    end
    // A released bus shows the inverse of the last word the master drove.
    assign bus = dut_oe ? dut_data : (drive ? wdata : ~last_q);
    // ********
    // Tasks, pins packed as {cs, oe, rd, wr, pkt}
    // ********
    task automatic pins(input logic [4:0] n, input logic dr, input logic [15:0] d);
        @(negedge clk);
        {cs_n, oe_n, rd_n, wr_n, pkt_n} = n;
        drive = dr;
        wdata = d;
    endtask
    task automatic step(input logic [4:0] n, input logic dr, input logic [15:0] d);
        pins(n, dr, d);
        repeat (6) @(negedge clk);
    endtask
    task automatic sync_cycle(input logic [4:0] n, input logic [15:0] d, output logic [15:0] seen);
        @(negedge interface_clock);
        pins(n, ~n[1], d);
        @(posedge interface_clock);
        seen = dut_data;
    endtask
    task automatic set_ep(input logic [2:0] ep, input logic mode);
        @(negedge interface_clock);
        @(negedge clk);
        ep_sel = ep;
        async_mode = mode;
        repeat (2) @(posedge interface_clock);
    endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the slave FIFO port.
`timescale 1ns/100ps
module testbench;
    logic        clk, arst_n, usb_push_valid, usb_pop_req;
    logic [1:0]  usb_push_ep, usb_pop_ep;
    logic [15:0] usb_push_data, seen, last_len, last_ep;
    int          n_errors, num_checks, n_commits;
    wire         interface_clock, async_mode, cs_n, oe_n, rd_n, wr_n, pkt_n, data_oe, empty, full;
    wire         push_ready, pop_ready, pop_valid, commit_pulse;
    wire [2:0]   ep_sel;
    wire [15:0]  bus, data_out, pop_data;
    wire [1:0]   commit_ep;
    wire [6:0]   commit_len;
    slave_fifo_rw_sequencer slave_fifo_rw_sequencer_inst (
        .clk(clk), .arst_n(arst_n), .interface_clock(interface_clock), .async_mode(async_mode),
        .fifo_chip_select_n(cs_n), .fifo_output_enable_n(oe_n), .fifo_read_strobe_n(rd_n),
        .fifo_write_strobe_n(wr_n), .packet_commit_strobe_n(pkt_n), .endpoint_select(ep_sel),
        .fifo_data_in(bus), .fifo_data_out(data_out), .fifo_data_oe(data_oe), .fifo_empty_flag(empty),
        .fifo_full_flag(full), .usb_push_valid(usb_push_valid), .usb_push_ep(usb_push_ep),
        .usb_push_data(usb_push_data), .usb_push_ready(push_ready), .usb_pop_req(usb_pop_req),
        .usb_pop_ep(usb_pop_ep), .usb_pop_ready(pop_ready), .usb_pop_data(pop_data),
        .usb_pop_data_valid(pop_valid), .commit_pulse(commit_pulse), .commit_ep(commit_ep),
        .commit_len(commit_len)
    );
    master_model master_model_inst (
        .clk(clk), .dut_data(data_out), .dut_oe(data_oe), .interface_clock(interface_clock),
        .async_mode(async_mode), .cs_n(cs_n), .oe_n(oe_n), .rd_n(rd_n), .wr_n(wr_n), .pkt_n(pkt_n),
        .ep_sel(ep_sel), .bus(bus)
    );
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (commit_pulse === 1'b1) begin
            n_commits++;
            last_len = {9'h000, commit_len};
            last_ep = {14'h0000, commit_ep};
        end
    end
    // ********
    // Shared tasks
    // ********
    // A handshake wait that runs out counts a mismatch and ends the run.
    task automatic bounded(input int k);
        if (k == 9) begin
            n_errors++;
            wrap_up;
        end
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic push(input logic [1:0] ep, input logic [15:0] d);
        int k;
        @(negedge clk);
        {usb_push_valid, usb_push_ep, usb_push_data} = {1'b1, ep, d};
        for (k = 0; k < 9; k++) begin
            @(posedge clk);
            if (push_ready === 1'b1) break;
        end
        @(negedge clk);
        usb_push_valid = 1'b0;
        bounded(k);
    endtask
    task automatic pop(input logic [1:0] ep, input logic [15:0] exp);
        int k;
        @(negedge clk);
        {usb_pop_req, usb_pop_ep} = {1'b1, ep};
        for (k = 0; k < 9; k++) begin
            @(posedge clk);
            if (pop_ready === 1'b1) break;
        end
        @(negedge clk);
        usb_pop_req = 1'b0;
        bounded(k);
        chk("pop valid", 16'h0001, {15'h0000, pop_valid});
        chk("popped word", exp, pop_data);
    endtask
    task automatic commit_chk(input int c0, input logic [15:0] len, input logic [15:0] ep);
        chk("commit count", 16'(c0 + 1), 16'(n_commits));
        chk("commit length", len, last_len);
        chk("commit endpoint", ep, last_ep);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_sync_write;
        int c0;
        c0 = n_commits;
        master_model_inst.set_ep(3'h1, 1'b0);
        master_model_inst.sync_cycle(5'h1D, 16'hDEAD, seen);
        for (int i = 1; i < 4; i++) master_model_inst.sync_cycle({4'h6, i != 3}, 16'(16'h1111 * i), seen);
        master_model_inst.sync_cycle(5'h0F, 16'h0000, seen);
        commit_chk(c0, 16'h0003, 16'h0001);
        for (int i = 1; i < 4; i++) pop(2'h1, 16'(16'h1111 * i));
        $display("test sync_write done");
    endtask
    task automatic t_sync_fill;
        int c0;
        c0 = n_commits;
        master_model_inst.set_ep(3'h3, 1'b0);
        for (int i = 0; i < 65; i++) master_model_inst.sync_cycle(5'h0D, 16'(16'h0100 + i), seen);
        master_model_inst.sync_cycle(5'h0F, 16'h0000, seen);
        chk("full flag", 16'h0001, {15'h0000, full});
        master_model_inst.sync_cycle(5'h0E, 16'h0000, seen);
        master_model_inst.sync_cycle(5'h0F, 16'h0000, seen);
        commit_chk(c0, 16'h0040, 16'h0003);
        pop(2'h3, 16'h0100);
        master_model_inst.set_ep(3'h1, 1'b0);
        chk("full other endpoint", 16'h0000, {15'h0000, full});
        $display("test sync_fill done");
    endtask
    task automatic t_sync_read;
        for (int i = 0; i < 4; i++) push(2'h2, 16'(16'hA000 + i));
        master_model_inst.set_ep(3'h2, 1'b0);
        chk("empty flag", 16'h0000, {15'h0000, empty});
        master_model_inst.sync_cycle(5'h07, 16'h0000, seen);
        chk("prefetched word", 16'hA000, seen);
        master_model_inst.sync_cycle(5'h0F, 16'h0000, seen);
        master_model_inst.sync_cycle(5'h07, 16'h0000, seen);
        chk("word after enable toggle", 16'hA000, seen);
        for (int i = 0; i < 4; i++) begin
            master_model_inst.sync_cycle(5'h03, 16'h0000, seen);
            chk("burst read word", 16'(16'hA000 + i), seen);
        end
        master_model_inst.sync_cycle(5'h0F, 16'h0000, seen);
        chk("empty after reads", 16'h0001, {15'h0000, empty});
        master_model_inst.set_ep(3'h5, 1'b0);
        chk("unused address flags", 16'h0003, {14'h0000, empty, full});
        $display("test sync_read done");
    endtask
    task automatic t_async;
        int c0;
        c0 = n_commits;
        master_model_inst.set_ep(3'h1, 1'b1);
        for (int i = 1; i < 3; i++) begin
            master_model_inst.step(5'h0D, 1'b1, 16'(16'hB000 + i));
            master_model_inst.step(5'h0F, 1'b1, 16'(16'hB000 + i));
        end
        master_model_inst.step(5'h0F, 1'b0, 16'h0000);
        master_model_inst.step(5'h0E, 1'b0, 16'h0000);
        master_model_inst.step(5'h0F, 1'b0, 16'h0000);
        commit_chk(c0, 16'h0002, 16'h0001);
        pop(2'h1, 16'hB001);
        pop(2'h1, 16'hB002);
        push(2'h0, 16'hC001);
        push(2'h0, 16'hC002);
        master_model_inst.set_ep(3'h0, 1'b1);
        master_model_inst.step(5'h03, 1'b0, 16'h0000);
        chk("async read word", 16'hC001, data_out);
        master_model_inst.step(5'h0F, 1'b0, 16'h0000);
        master_model_inst.step(5'h07, 1'b0, 16'h0000);
        chk("early enable word", 16'hC001, data_out);
        master_model_inst.step(5'h03, 1'b0, 16'h0000);
        chk("second async word", 16'hC002, data_out);
        master_model_inst.step(5'h0F, 1'b0, 16'h0000);
        $display("test async done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        {clk, arst_n, usb_push_valid, usb_pop_req} = 4'h0;
        {usb_push_ep, usb_pop_ep, usb_push_data} = 20'h00000;
        {n_errors, num_checks, n_commits} = '0;
        {last_len, last_ep} = 32'h00000000;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_sync_write;
        t_sync_fill;
        t_sync_read;
        t_async;
        wrap_up;
    end
    // A hang anywhere still ends in the closing report.
    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
endmodule
